//--- logic/ssr_pkg.sv
// Constants shared by the system supervisor reset block
package ssr_pkg;

  // ==================== Timing ====================
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned POR_TIME_NS   = 10000;
  localparam int unsigned MIN_RST_NS    = 1000;
  localparam int unsigned POR_CYC = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EXT_CYC = (MIN_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==================== Register offsets ====================
  localparam logic [7:0] OFF_RST_STATUS = 8'h00;
  localparam logic [7:0] OFF_LVD_CTRL   = 8'h04;
  localparam logic [7:0] OFF_IRQ_EN     = 8'h08;
  localparam logic [7:0] OFF_BO_STATUS  = 8'h0C;
  localparam logic [7:0] OFF_WD_CTRL    = 8'h10;
  localparam logic [7:0] OFF_WD_PRESC   = 8'h14;
  localparam logic [7:0] OFF_WD_RELOAD  = 8'h18;
  localparam logic [7:0] OFF_WD_KICK    = 8'h1C;
  localparam logic [7:0] OFF_WD_COUNT   = 8'h20;
  localparam logic [7:0] OFF_TAMP_CTRL  = 8'h24;
  localparam logic [7:0] OFF_RTC_CFG    = 8'h28;
  localparam logic [7:0] OFF_TAMP_TIME  = 8'h2C;
  localparam logic [7:0] OFF_TAMP_DATE  = 8'h30;

  // ==================== Fields ====================
  localparam int unsigned ST_WD_BIT   = 0;
  localparam int unsigned ST_DROP_BIT = 1;
  localparam int unsigned ST_EXT_BIT  = 2;
  localparam int unsigned ST_DBG_BIT  = 3;
  localparam int unsigned LVD_SUP_IO_BIT = 0;
  localparam int unsigned LVD_SUP_BO_BIT = 1;
  localparam int unsigned LVD_OFF_BIT    = 2;
  localparam int unsigned WD_EN_BIT   = 0;
  localparam int unsigned WD_MODE_BIT = 1;
  localparam int unsigned TP_EN_BIT   = 0;
  localparam int unsigned TP_RISE_BIT = 1;
  localparam int unsigned TP_FLAG_BIT = 8;

  // ==================== Reset values and constants ====================
  localparam logic [2:0]  LVD_CTRL_RST  = 3'h2;
  localparam logic [1:0]  IRQ_EN_RST    = 2'h0;
  localparam logic [1:0]  WD_CTRL_RST   = 2'h0;
  localparam logic [7:0]  WD_PRESC_RST  = 8'hFF;
  localparam logic [15:0] WD_RELOAD_RST = 16'hFFFF;
  localparam logic [15:0] WD_TERM       = 16'h0000;
  localparam logic [31:0] BOOT_ADDR     = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {ST_GLOB, ST_CNT, ST_RUN} ssr_state_t;

endpackage : ssr_pkg

//--- logic/ssr_sync.sv
// Two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ns
module ssr_sync #(
  parameter int unsigned      W   = 1,
  parameter logic [W-1:0]     RST = '0
) (
  input  wire logic         core_clk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta;

  // ==================== Per-bit stages ====================
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        meta[i]   <= RST[i];
        sync_o[i] <= RST[i];
      end else begin
        meta[i]   <= async_i[i];
        sync_o[i] <= meta[i];
      end
    end
  end

endmodule : ssr_sync

//--- logic/ssr_top.sv
// System supervisor: reset sequencing, low-voltage, watchdog, tamper, AXI4-Lite registers
//
// Overview of operation
// - Global and system reset clear the same control registers; only a power-up global reset clears reset status.
// - Supply dropout, brownout, power-up give global reset; watchdog, pin, debug give system.
// - Readable reset-cause register shows watchdog or dropout; only power-up clears it.
// - Brownout on either supply raises an early-warning interrupt.
// - Firmware interrupt mask bits can suppress every brownout warning.
// - Core-supply dropout always forces global reset; nothing can mask it.
// - I/O dropout threshold picked from two levels by nonvolatile configuration.
// - Firmware can suppress selected low-voltage resets, or disable the detector.
// - Separate 16-bit down-counter works as watchdog or free-running counter.
// - Counter is clocked from the core clock through an 8-bit prescaler.
// - Without periodic reload, reaching terminal count issues a system reset.
// - Watchdog is disabled after every reset until firmware enables it.
// - Reset pin held low for the minimum time causes a system reset.
// - Active-low board reset output lasts as long as the power-on reset.
// - Power-up reset holds until both supplies are good, then lasts its duration.
// - After reset the CPU fetches from the flash base address only.
// - Debug-port reset command in debug mode causes a system reset.
// - Tamper input detects rising or falling edge as selected by firmware.
// - Tamper event captures current time and date into record registers.
// - Tamper event cuts the SRAM standby supply at once.
// - Core supply below threshold switches SRAM to battery, even with detector off, as its global reset re-enables it.
// - Configuration selects whether battery feeds only the clock or also SRAM.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
module ssr_top (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        por_i,
  input  wire logic        core_ok_i,
  input  wire logic        io_ok_lo_i,
  input  wire logic        io_ok_hi_i,
  input  wire logic        core_bo_i,
  input  wire logic        io_bo_i,
  input  wire logic        io_thr_sel_i,
  input  wire logic        ext_reset_in_low_i,
  input  wire logic        dbg_mode_i,
  input  wire logic        dbg_reset_cmd_i,
  input  wire logic        tamper_i,
  input  wire logic [31:0] rtc_time_i,
  input  wire logic [31:0] rtc_date_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic             global_reset_o,
  output logic             system_reset_o,
  output logic             board_reset_out_low_o,
  output logic [31:0]      boot_addr_o,
  output logic             brownout_irq_o,
  output logic             sram_on_battery_o,
  output logic             sram_standby_cut_o,
  output logic             battery_feeds_sram_o,
  output logic             tamper_capture_o
);

  // ==================== Pin synchronisers ====================
  logic por_s, core_ok_s, io_ok_lo_s, io_ok_hi_s, core_bo_s, io_bo_s;
  logic io_thr_sel_s, ext_low_s, dbg_mode_s, dbg_cmd_s, tamper_s;

  ssr_sync #(
    .W   (11),
    .RST (11'h790)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .async_i    ({por_i, core_ok_i, io_ok_lo_i, io_ok_hi_i, core_bo_i, io_bo_i,
                  ext_reset_in_low_i, dbg_mode_i, dbg_reset_cmd_i, tamper_i, io_thr_sel_i}),
    .sync_o     ({por_s, core_ok_s, io_ok_lo_s, io_ok_hi_s, core_bo_s, io_bo_s,
                  ext_low_s, dbg_mode_s, dbg_cmd_s, tamper_s, io_thr_sel_s})
  );

  // ==================== Registers and bus state ====================
  ssr_pkg::ssr_state_t state;
  logic        gkind;
  logic [15:0] por_cnt;
  logic [3:0]  rst_status;
  logic [2:0]  lvd_ctrl;
  logic [1:0]  irq_en;
  logic [1:0]  wd_ctrl;
  logic [7:0]  wd_presc;
  logic [15:0] wd_reload;
  logic [15:0] wd_count;
  logic        wd_timeout;
  logic [1:0]  tamp_ctrl;
  logic        tamp_flag;
  logic        tamp_q;
  logic        rtc_cfg;
  logic [31:0] tamp_time;
  logic [31:0] tamp_date;
  logic [15:0] ext_cnt;
  logic        ext_valid;
  logic        dbg_cmd_q;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [31:0] wm;
  logic        do_wr;
  logic        wr_hit;
  logic [31:0] rd_val;
  logic        rd_hit;

  // ==================== Reset sources ====================
  logic       in_rst, clr, core_bad, io_ok, lvd_on, io_drop, bo_rst, dbg_req, gr_req, sr_req;
  logic [1:0] bo_vec;
  logic       tamp_evt;

  assign in_rst   = (state != ssr_pkg::ST_RUN);
  assign clr      = srst_i || in_rst;
  assign core_bad = !core_ok_s;
  assign io_ok    = io_thr_sel_s ? io_ok_hi_s : io_ok_lo_s;
  assign lvd_on   = !lvd_ctrl[ssr_pkg::LVD_OFF_BIT];
  assign io_drop  = lvd_on && !io_ok && !lvd_ctrl[ssr_pkg::LVD_SUP_IO_BIT];
  assign bo_vec   = {io_bo_s, core_bo_s};
  assign bo_rst   = lvd_on && (|bo_vec) && !lvd_ctrl[ssr_pkg::LVD_SUP_BO_BIT];
  assign dbg_req  = dbg_mode_s && dbg_cmd_s && !dbg_cmd_q;
  assign gr_req   = por_s || core_bad || io_drop || bo_rst;
  assign sr_req   = wd_timeout || ext_valid || dbg_req;

  // External pin must stay low a minimum time
  always_ff @(posedge core_clk_i) begin
    if (srst_i || ext_low_s) begin
      ext_cnt   <= 16'h0000;
      ext_valid <= 1'b0;
    end else begin
      ext_valid <= (ext_cnt == 16'(ssr_pkg::EXT_CYC - 1));
      if (ext_cnt != 16'(ssr_pkg::EXT_CYC)) begin
        ext_cnt <= ext_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      dbg_cmd_q <= 1'b0;
    end else begin
      dbg_cmd_q <= dbg_cmd_s;
    end
  end

  // ==================== Reset sequencer ====================
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state   <= ssr_pkg::ST_GLOB;
      gkind   <= 1'b1;
      por_cnt <= 16'h0000;
    end else if (gr_req) begin
      state   <= ssr_pkg::ST_GLOB;
      gkind   <= 1'b1;
      por_cnt <= 16'h0000;
    end else begin
      unique case (state)
        ssr_pkg::ST_GLOB: begin
          state <= ssr_pkg::ST_CNT;
        end
        ssr_pkg::ST_CNT: begin
          if (por_cnt == 16'(ssr_pkg::POR_CYC - 1)) begin
            state <= ssr_pkg::ST_RUN;
          end else begin
            por_cnt <= por_cnt + 16'h0001;
          end
        end
        ssr_pkg::ST_RUN: begin
          if (sr_req) begin
            state   <= ssr_pkg::ST_CNT;
            gkind   <= 1'b0;
            por_cnt <= 16'h0000;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      global_reset_o        <= 1'b1;
      system_reset_o        <= 1'b1;
      board_reset_out_low_o <= 1'b0;
      boot_addr_o           <= ssr_pkg::BOOT_ADDR;
    end else begin
      global_reset_o        <= in_rst && gkind;
      system_reset_o        <= in_rst;
      board_reset_out_low_o <= !in_rst;
      boot_addr_o           <= ssr_pkg::BOOT_ADDR;
    end
  end

  // Cause bits survive system resets
  always_ff @(posedge core_clk_i) begin
    if (srst_i || por_s) begin
      rst_status <= 4'h0;
    end else begin
      rst_status[ssr_pkg::ST_WD_BIT]   <= rst_status[ssr_pkg::ST_WD_BIT] || wd_timeout;
      rst_status[ssr_pkg::ST_DROP_BIT] <= rst_status[ssr_pkg::ST_DROP_BIT] || core_bad || io_drop;
      rst_status[ssr_pkg::ST_EXT_BIT]  <= rst_status[ssr_pkg::ST_EXT_BIT] || ext_valid;
      rst_status[ssr_pkg::ST_DBG_BIT]  <= rst_status[ssr_pkg::ST_DBG_BIT] || dbg_req;
    end
  end

  // ==================== AXI4-Lite write channel ====================
  assign wm    = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign do_wr = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
  assign wr_hit = (aw_addr == ssr_pkg::OFF_LVD_CTRL) || (aw_addr == ssr_pkg::OFF_IRQ_EN) ||
                  (aw_addr == ssr_pkg::OFF_WD_CTRL) || (aw_addr == ssr_pkg::OFF_WD_PRESC) ||
                  (aw_addr == ssr_pkg::OFF_WD_RELOAD) || (aw_addr == ssr_pkg::OFF_WD_KICK) ||
                  (aw_addr == ssr_pkg::OFF_TAMP_CTRL) || (aw_addr == ssr_pkg::OFF_RTC_CFG);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= ssr_pkg::RESP_OKAY;
      aw_addr         <= 8'h00;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        s_axi_awready_o <= 1'b0;
        aw_addr         <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        s_axi_wready_o <= 1'b0;
        w_data         <= s_axi_wdata_i;
        w_strb         <= s_axi_wstrb_i;
      end
      if (do_wr) begin
        s_axi_bvalid_o  <= 1'b1;
        s_axi_bresp_o   <= wr_hit ? ssr_pkg::RESP_OKAY : ssr_pkg::RESP_SLVERR;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // ==================== Control registers ====================
  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      lvd_ctrl <= ssr_pkg::LVD_CTRL_RST;
      irq_en   <= ssr_pkg::IRQ_EN_RST;
    end else if (do_wr && aw_addr == ssr_pkg::OFF_LVD_CTRL) begin
      lvd_ctrl <= (lvd_ctrl & ~wm[2:0]) | (w_data[2:0] & wm[2:0]);
    end else if (do_wr && aw_addr == ssr_pkg::OFF_IRQ_EN) begin
      irq_en <= (irq_en & ~wm[1:0]) | (w_data[1:0] & wm[1:0]);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      wd_ctrl   <= ssr_pkg::WD_CTRL_RST;
      wd_presc  <= ssr_pkg::WD_PRESC_RST;
      wd_reload <= ssr_pkg::WD_RELOAD_RST;
    end else if (do_wr && aw_addr == ssr_pkg::OFF_WD_CTRL) begin
      wd_ctrl <= (wd_ctrl & ~wm[1:0]) | (w_data[1:0] & wm[1:0]);
    end else if (do_wr && aw_addr == ssr_pkg::OFF_WD_PRESC) begin
      wd_presc <= (wd_presc & ~wm[7:0]) | (w_data[7:0] & wm[7:0]);
    end else if (do_wr && aw_addr == ssr_pkg::OFF_WD_RELOAD) begin
      wd_reload <= (wd_reload & ~wm[15:0]) | (w_data[15:0] & wm[15:0]);
    end
  end

  ssr_wdog u_wdog (
    .core_clk_i (core_clk_i),
    .clr_i      (clr),
    .en_i       (wd_ctrl[ssr_pkg::WD_EN_BIT]),
    .wd_mode_i  (wd_ctrl[ssr_pkg::WD_MODE_BIT]),
    .presc_i    (wd_presc),
    .reload_i   (wd_reload),
    .kick_i     (do_wr && aw_addr == ssr_pkg::OFF_WD_KICK),
    .count_o    (wd_count),
    .timeout_o  (wd_timeout)
  );

  // ==================== Tamper and battery ====================
  assign tamp_evt = tamp_ctrl[ssr_pkg::TP_EN_BIT] &&
                    (tamp_ctrl[ssr_pkg::TP_RISE_BIT] ? (tamper_s && !tamp_q) : (!tamper_s && tamp_q));

  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      tamp_ctrl <= 2'h0;
      tamp_flag <= 1'b0;
      rtc_cfg   <= 1'b0;
      tamp_q    <= 1'b0;
      tamp_time <= 32'h0000_0000;
      tamp_date <= 32'h0000_0000;
    end else begin
      tamp_q <= tamper_s;
      if (tamp_evt) begin
        tamp_flag <= 1'b1;
        tamp_time <= rtc_time_i;
        tamp_date <= rtc_date_i;
      end else if (do_wr && aw_addr == ssr_pkg::OFF_TAMP_CTRL && wm[ssr_pkg::TP_FLAG_BIT] &&
                   w_data[ssr_pkg::TP_FLAG_BIT]) begin
        tamp_flag <= 1'b0;
      end
      if (do_wr && aw_addr == ssr_pkg::OFF_TAMP_CTRL) begin
        tamp_ctrl <= (tamp_ctrl & ~wm[1:0]) | (w_data[1:0] & wm[1:0]);
      end
      if (do_wr && aw_addr == ssr_pkg::OFF_RTC_CFG && wm[0]) begin
        rtc_cfg <= w_data[0];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      brownout_irq_o       <= 1'b0;
      sram_on_battery_o    <= 1'b0;
      sram_standby_cut_o   <= 1'b0;
      battery_feeds_sram_o <= 1'b0;
      tamper_capture_o     <= 1'b0;
    end else begin
      brownout_irq_o       <= lvd_on && |(bo_vec & irq_en);
      sram_on_battery_o    <= lvd_on && core_bad;
      sram_standby_cut_o   <= tamp_evt || tamp_flag;
      battery_feeds_sram_o <= rtc_cfg && !tamp_evt && !tamp_flag;
      tamper_capture_o     <= tamp_evt;
    end
  end

  // ==================== AXI4-Lite read channel ====================
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr_i)
      ssr_pkg::OFF_RST_STATUS: rd_val[3:0]  = rst_status;
      ssr_pkg::OFF_LVD_CTRL:   rd_val[2:0]  = lvd_ctrl;
      ssr_pkg::OFF_IRQ_EN:     rd_val[1:0]  = irq_en;
      ssr_pkg::OFF_BO_STATUS:  rd_val[1:0]  = bo_vec;
      ssr_pkg::OFF_WD_CTRL:    rd_val[1:0]  = wd_ctrl;
      ssr_pkg::OFF_WD_PRESC:   rd_val[7:0]  = wd_presc;
      ssr_pkg::OFF_WD_RELOAD:  rd_val[15:0] = wd_reload;
      ssr_pkg::OFF_WD_KICK:    rd_val       = 32'h0000_0000;
      ssr_pkg::OFF_WD_COUNT:   rd_val[15:0] = wd_count;
      ssr_pkg::OFF_TAMP_CTRL:  rd_val       = {23'h0, tamp_flag, 6'h00, tamp_ctrl};
      ssr_pkg::OFF_RTC_CFG:    rd_val[0]    = rtc_cfg;
      ssr_pkg::OFF_TAMP_TIME:  rd_val       = tamp_time;
      ssr_pkg::OFF_TAMP_DATE:  rd_val       = tamp_date;
      default:                 rd_hit       = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= ssr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rd_val;
      s_axi_rresp_o   <= rd_hit ? ssr_pkg::RESP_OKAY : ssr_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // ==================== Checks ====================
  AST_CORE_DROP: assert property (@(posedge core_clk_i) disable iff (srst_i)
    core_bad |-> ##[1:2] global_reset_o && !board_reset_out_low_o)
    else $error("Core dropout did not force global reset");

  AST_SYS_KIND: assert property (@(posedge core_clk_i) disable iff (srst_i)
    state == ssr_pkg::ST_RUN && sr_req && !gr_req |=> ##1 system_reset_o && !global_reset_o)
    else $error("System reset source produced wrong reset kind");

  AST_POR_HOLD: assert property (@(posedge core_clk_i) disable iff (srst_i)
    gr_req |=> state == ssr_pkg::ST_GLOB && por_cnt == 16'h0000)
    else $error("Reset released while supplies bad");

  AST_STATUS_KEEP: assert property (@(posedge core_clk_i) disable iff (srst_i || por_s)
    ##1 (($past(rst_status) & ~rst_status) == 4'h0))
    else $error("Reset status bit lost without power-up");

  AST_WD_OFF: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(board_reset_out_low_o) |-> wd_ctrl == 2'h0 && !wd_timeout)
    else $error("Watchdog enabled on leaving reset");

  AST_IRQ: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (bo_vec & irq_en) == 2'h0 |=> !brownout_irq_o)
    else $error("Masked brownout reached interrupt");

  AST_TAMPER: assert property (@(posedge core_clk_i) disable iff (clr)
    tamp_evt |=> sram_standby_cut_o && tamper_capture_o && !battery_feeds_sram_o && tamp_time == $past(rtc_time_i))
    else $error("Tamper event did not cut SRAM supply");

  AST_EXT_RST: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ext_valid && state == ssr_pkg::ST_RUN && !gr_req |=> state == ssr_pkg::ST_CNT && !gkind)
    else $error("Valid reset pin pulse ignored");

  AST_BOOT: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(board_reset_out_low_o) |-> boot_addr_o == ssr_pkg::BOOT_ADDR && !system_reset_o)
    else $error("Boot address not flash base");

endmodule : ssr_top

//--- logic/ssr_wdog.sv
// Watchdog / free-running down-counter with 8-bit prescaler
`timescale 1ns/1ns
module ssr_wdog (
  input  wire logic        core_clk_i,
  input  wire logic        clr_i,
  input  wire logic        en_i,
  input  wire logic        wd_mode_i,
  input  wire logic [7:0]  presc_i,
  input  wire logic [15:0] reload_i,
  input  wire logic        kick_i,
  output logic      [15:0] count_o,
  output logic             timeout_o
);

  logic [7:0] pre;
  logic       tick;

  assign tick = en_i && !kick_i && (pre == 8'h00);

  // ==================== Prescaler ====================
  always_ff @(posedge core_clk_i) begin
    if (clr_i || kick_i || !en_i) begin
      pre <= presc_i;
    end else if (pre == 8'h00) begin
      pre <= presc_i;
    end else begin
      pre <= pre - 8'h01;
    end
  end

  // ==================== Counter ====================
  always_ff @(posedge core_clk_i) begin
    if (clr_i) begin
      count_o   <= ssr_pkg::WD_RELOAD_RST;
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= tick && wd_mode_i && ((count_o - 16'h0001) == ssr_pkg::WD_TERM);
      if (kick_i) begin
        count_o <= reload_i;
      end else if (tick) begin
        count_o <= (count_o == ssr_pkg::WD_TERM) ? reload_i : count_o - 16'h0001;
      end
    end
  end

  AST_WD_TIMEOUT: assert property (@(posedge core_clk_i) disable iff (clr_i)
    tick && wd_mode_i && count_o == 16'h0001 |=> timeout_o && count_o == ssr_pkg::WD_TERM)
    else $error("Watchdog missed terminal count");

  AST_WD_KICK: assert property (@(posedge core_clk_i) disable iff (clr_i)
    kick_i |=> count_o == $past(reload_i) && pre == $past(presc_i) && !timeout_o)
    else $error("Watchdog reload did not restore counter and prescaler");

endmodule : ssr_wdog

//--- testbench/ssr_board.sv
// Board-side model driving the external reset pin
`timescale 1ns/1ns
module ssr_board #(
  parameter int unsigned LOW_CYC = ssr_pkg::EXT_CYC + 5
) (
  input  wire logic core_clk_i,
  input  wire logic go_i,
  output logic      ext_reset_in_low_o
);
  int unsigned left = 0;
  // Held low past the minimum time, pull-up level otherwise
  always_ff @(posedge core_clk_i) begin
    if (go_i) left <= LOW_CYC;
    else if (left != 0) left <= left - 1;
  end
  assign ext_reset_in_low_o = (left == 0);
endmodule : ssr_board

//--- testbench/testbench.sv
// Self-checking bench for the system supervisor reset block
`timescale 1ns/1ns
module testbench;
  logic        clk = 0, srst = 1, por = 0, cok = 1, cbo = 0, ibo = 0, dm = 0, dc = 0, go = 0;
  logic        iol = 1, tp = 0, sob, cut, bfs, tcap;
  logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0, awr, wr_r, bv, arr, rv, glob, sys, brd, irq, pin;
  logic [7:0]  awa = '0, ara = '0;
  logic [31:0] wd = '0, rtm = '0, rdt = '0, rd_d, boot;
  logic [1:0]  bresp, rresp;
  logic [33:0] exp_q[$];
  int          num_errors = 0, checked = 0, cyc = 0;
  always #20 clk = ~clk;
  ssr_board ssr_board_inst (.core_clk_i(clk), .go_i(go), .ext_reset_in_low_o(pin));
  ssr_top ssr_top_inst (.core_clk_i(clk), .srst_i(srst), .por_i(por), .core_ok_i(cok), .io_ok_lo_i(iol),
    .io_ok_hi_i(1'b0), .core_bo_i(cbo), .io_bo_i(ibo), .io_thr_sel_i(1'b0), .ext_reset_in_low_i(pin),
    .dbg_mode_i(dm), .dbg_reset_cmd_i(dc), .tamper_i(tp), .rtc_time_i(rtm), .rtc_date_i(rdt),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd_d), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rr), .global_reset_o(glob), .system_reset_o(sys), .board_reset_out_low_o(brd),
    .boot_addr_o(boot), .brownout_irq_o(irq), .sram_on_battery_o(sob), .sram_standby_cut_o(cut),
    .battery_feeds_sram_o(bfs), .tamper_capture_o(tcap));
  // ==================== Checking ====================
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    if (((rv && rr) || (bv && br)) && exp_q.size() > 0) begin
      chk(rv ? {rresp, rd_d} : {bresp, 32'h0}, exp_q.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      give_verdict();
    end
  end
  // ==================== Bus and reset tasks ====================
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = ssr_pkg::RESP_OKAY);
    @(posedge clk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    exp_q.push_back({r, 32'h0});
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
    end while (!(bv && br));
    br <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    exp_q.push_back({r, e});
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (!(rv && rr));
    rr <= 1'b0;
  endtask : rd
  // Waits for a reset, checks its class, then waits it out
  task automatic sys_rst(input logic g);
    int n;
    for (n = 0; n < 400 && sys !== 1'b1; n++) @(posedge clk);
    chk(34'(sys), 34'h1);
    chk(34'(glob), 34'(g));
    for (n = 0; n < 2000 && sys !== 1'b0; n++) @(posedge clk);
    chk(34'(sys), 34'h0);
  endtask : sys_rst
  // ==================== Scenarios ====================
  initial begin
    logic [15:0] rld;
    void'($urandom(65262));
    rld = 16'(40 + $urandom % 24);
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rtm  <= $urandom;
    rdt  <= $urandom;
    sys_rst(1'b1);
    chk(34'(brd), 34'h1);
    chk(34'(boot), 34'(ssr_pkg::BOOT_ADDR));
    rd(ssr_pkg::OFF_RST_STATUS, 32'h0, ssr_pkg::RESP_OKAY);
    rd(ssr_pkg::OFF_LVD_CTRL, 32'(ssr_pkg::LVD_CTRL_RST), ssr_pkg::RESP_OKAY);
    rd(8'hFC, 32'h0, ssr_pkg::RESP_SLVERR);
    wr(ssr_pkg::OFF_IRQ_EN, 32'h3);
    cbo <= 1'b1;
    ibo <= 1'b1;
    repeat (5) @(posedge clk);
    chk(34'(irq), 34'h1);
    wr(ssr_pkg::OFF_IRQ_EN, 32'h0);
    repeat (5) @(posedge clk);
    chk(34'(irq), 34'h0);
    cbo <= 1'b0;
    ibo <= 1'b0;
    wr(ssr_pkg::OFF_WD_PRESC, 32'h0);
    wr(ssr_pkg::OFF_WD_RELOAD, 32'(rld));
    wr(ssr_pkg::OFF_WD_CTRL, 32'h3);
    repeat (4) begin
      repeat (rld / 4) @(posedge clk);
      wr(ssr_pkg::OFF_WD_KICK, 32'h0);
    end
    chk(34'(sys), 34'h0);
    sys_rst(1'b0);
    wr(ssr_pkg::OFF_RST_STATUS, 32'hF, ssr_pkg::RESP_SLVERR);
    rd(ssr_pkg::OFF_RST_STATUS, 32'h1, ssr_pkg::RESP_OKAY);
    rd(ssr_pkg::OFF_WD_CTRL, 32'h0, ssr_pkg::RESP_OKAY);
    rd(ssr_pkg::OFF_WD_RELOAD, 32'(ssr_pkg::WD_RELOAD_RST), ssr_pkg::RESP_OKAY);
    // Tamper on rising then falling edge
    wr(ssr_pkg::OFF_TAMP_CTRL, 32'h3);
    tp <= 1'b1;
    do @(posedge clk); while (tcap !== 1'b1);
    chk(34'(cut), 34'h1);
    rd(ssr_pkg::OFF_TAMP_CTRL, 32'h103, ssr_pkg::RESP_OKAY);
    rd(ssr_pkg::OFF_TAMP_TIME, rtm, ssr_pkg::RESP_OKAY);
    rd(ssr_pkg::OFF_TAMP_DATE, rdt, ssr_pkg::RESP_OKAY);
    wr(ssr_pkg::OFF_RTC_CFG, 32'h1);
    chk(34'(bfs), 34'h0);
    wr(ssr_pkg::OFF_TAMP_CTRL, 32'h101);
    repeat (2) @(posedge clk);
    chk(34'(cut), 34'h0);
    chk(34'(bfs), 34'h1);
    tp <= 1'b0;
    do @(posedge clk); while (tcap !== 1'b1);
    chk(34'(bfs), 34'h0);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    sys_rst(1'b0);
    dm <= 1'b1;
    dc <= 1'b1;
    sys_rst(1'b0);
    dc <= 1'b0;
    wr(ssr_pkg::OFF_LVD_CTRL, 32'h7);
    cok <= 1'b0;
    repeat (10) @(posedge clk);
    chk(34'(sob), 34'h1);
    cok <= 1'b1;
    sys_rst(1'b1);
    iol <= 1'b0;
    repeat (10) @(posedge clk);
    iol <= 1'b1;
    sys_rst(1'b1);
    por <= 1'b1;
    repeat (300) @(posedge clk);
    chk(34'(glob), 34'h1);
    por <= 1'b0;
    sys_rst(1'b1);
    rd(ssr_pkg::OFF_RST_STATUS, 32'h0, ssr_pkg::RESP_OKAY);
    give_verdict();
  end
endmodule : testbench
